// File: mcf_alu.v
`timescale 1ns/1ps
`include "mcf_core_regs.vh"
module mcf_alu (
  // Operands
  input wire [7:0] opA,
  input wire [7:0] accIn,
  input wire carryIn,
  input wire [3:0] aluOp,
  // Result and flags
  output reg [7:0] result,
  output reg carryOut,
  output reg nibbleOut,
  output wire zeroOut
);
  wire [8:0] sumFull = {1'b0, opA} + {1'b0, accIn};
  wire [4:0] sumNib = {1'b0, opA[3:0]} + {1'b0, accIn[3:0]};
  // Carry out of a + ~w + 1 is already the inverted borrow
  wire [8:0] difFull = {1'b0, opA} + {1'b0, ~accIn} + 9'h001;
  wire [4:0] difNib = {1'b0, opA[3:0]} + {1'b0, ~accIn[3:0]} + 5'h01;

  assign zeroOut = (result == 8'h00);

  always @* begin
    result = opA;
    carryOut = carryIn;
    nibbleOut = 1'b0;
    case (aluOp)
      `MCF_ALU_CLR: result = 8'h00;
      `MCF_ALU_SUB: begin
        result = difFull[7:0];
        carryOut = difFull[8];
        nibbleOut = difNib[4];
      end
      `MCF_ALU_DEC: result = opA - 8'h01;
      `MCF_ALU_IOR: result = opA | accIn;
      `MCF_ALU_AND: result = opA & accIn;
      `MCF_ALU_XOR: result = opA ^ accIn;
      `MCF_ALU_ADD: begin
        result = sumFull[7:0];
        carryOut = sumFull[8];
        nibbleOut = sumNib[4];
      end
      `MCF_ALU_COM: result = ~opA;
      `MCF_ALU_INC: result = opA + 8'h01;
      `MCF_ALU_RR: begin
        result = {carryIn, opA[7:1]};
        carryOut = opA[0];
      end
      `MCF_ALU_RL: begin
        result = {opA[6:0], carryIn};
        carryOut = opA[7];
      end
      `MCF_ALU_SWAP: result = {opA[3:0], opA[7:4]};
      default: result = opA;
    endcase
  end
endmodule

// File: mcf_core.v
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "mcf_core_regs.vh"
module mcf_core (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Program ROM
  output wire [9:0] romAddr,
  input wire [13:0] romData,
  // Write-only plane
  output reg wpWrEn_r,
  output reg [2:0] wpAddr_r,
  output reg [7:0] wpData_r,
  // Interrupt request and core state
  input wire irqReq,
  output wire phaseTwo,
  output wire intBusy,
  // Wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  output wire wbAck,
  output wire [31:0] wbDatR
);
  localparam PH_ONE = 1'b0;
  localparam PH_TWO = 1'b1;

  reg phase_r;
  reg runEn_r;
  reg [9:0] pc_r;
  reg [13:0] ir_r;
  reg irValid_r;
  reg [7:0] acc_r;
  reg [7:0] status_r;
  reg [7:0] pointer_r;
  reg intBusy_r;
  reg intRetSeen_r;
  reg [7:0] ram_r [0:`MCF_RAM_WORDS-1];
  reg wbAck_r;
  reg [31:0] wbDatR_r;

  // ----------------------------------------
  // Decode of the word in execute
  // ----------------------------------------
  wire execEdge = runEn_r & (phase_r == PH_TWO);
  wire [1:0] grp = ir_r[13:12];
  wire [3:0] byteOp = ir_r[11:8];
  wire destFile = ir_r[7];
  wire [1:0] bitOp = ir_r[11:10];
  wire [2:0] bitSel = ir_r[9:7];
  wire [7:0] litVal = ir_r[7:0];
  wire [3:0] litOp = ir_r[11:8];
  wire isByte = irValid_r & (grp == `MCF_GRP_BYTE);
  wire isBit = irValid_r & (grp == `MCF_GRP_BIT);
  wire isJump = irValid_r & (grp == `MCF_GRP_JUMP);
  wire isLit = irValid_r & (grp == `MCF_GRP_LIT);
  wire isCall = isJump & ~ir_r[11];
  wire isMisc = isByte & (byteOp == `MCF_OP_MISC);
  wire isRet = isMisc & (ir_r[2:0] == `MCF_MISC_RET);
  wire isIntRet = isMisc & (ir_r[2:0] == `MCF_MISC_INTRET);
  wire isLitRet = isLit & (litOp == `MCF_LIT_RETVAL);
  wire doPop = isRet | isIntRet | isLitRet;
  wire isMove = isByte & (byteOp == `MCF_OP_MOVWF);
  wire isMovwf = isMove & destFile;
  wire isToWplane = isMove & ~destFile;
  wire byteWr = isByte & ~isMove & ~isMisc & (byteOp != `MCF_OP_NONE);
  wire litKnown = (litOp <= `MCF_LIT_XORLW);

  // ----------------------------------------
  // File plane addressing
  // ----------------------------------------
  // Bit forms carry only five address bits, so the upper half is reachable only through the pointer
  wire [5:0] dirAddr = isBit ? {1'b0, ir_r[4:0]} : ir_r[5:0];
  wire [5:0] physAddr = (dirAddr == `MCF_FA_INDIRECT) ? pointer_r[5:0] : dirAddr;
  wire isRam = (physAddr >= `MCF_FA_RAM_BASE);
  wire [5:0] ramIdx = physAddr - `MCF_FA_RAM_BASE;
  reg [7:0] fileRd;

  always @* begin
    case (physAddr)
      `MCF_FA_INDIRECT: fileRd = 8'h00;
      `MCF_FA_PCLOW: fileRd = pc_r[7:0];
      `MCF_FA_STATUS: fileRd = status_r;
      `MCF_FA_POINTER: fileRd = pointer_r;
      default: fileRd = isRam ? ram_r[ramIdx] : 8'h00;
    endcase
  end

  // ----------------------------------------
  // Arithmetic unit
  // ----------------------------------------
  reg [3:0] aluOp;
  reg [2:0] affMask;
  wire [7:0] opA = isLit ? litVal : fileRd;
  wire [7:0] aluRes;
  wire aluC;
  wire aluNib;
  wire aluZ;

  always @* begin
    aluOp = byteOp;
    if (isLit) begin
      case (litOp)
        `MCF_LIT_ADDLW: aluOp = `MCF_ALU_ADD;
        `MCF_LIT_SUBLW: aluOp = `MCF_ALU_SUB;
        `MCF_LIT_ANDLW: aluOp = `MCF_ALU_AND;
        `MCF_LIT_IORLW: aluOp = `MCF_ALU_IOR;
        `MCF_LIT_XORLW: aluOp = `MCF_ALU_XOR;
        default: aluOp = `MCF_ALU_PASS;
      endcase
    end
  end

  // Flag mask order is zero, nibble, carry
  always @* begin
    affMask = 3'b000;
    if (isLit | byteWr) begin
      case (aluOp)
        `MCF_ALU_SUB, `MCF_ALU_ADD: affMask = 3'b111;
        `MCF_ALU_RR, `MCF_ALU_RL: affMask = 3'b001;
        `MCF_ALU_PASS, `MCF_ALU_SWAP: affMask = 3'b000;
        default: affMask = 3'b100;
      endcase
    end
  end

  mcf_alu uAlu (
    .opA(opA),
    .accIn(acc_r),
    .carryIn(status_r[0]),
    .aluOp(aluOp),
    .result(aluRes),
    .carryOut(aluC),
    .nibbleOut(aluNib),
    .zeroOut(aluZ)
  );

  // ----------------------------------------
  // Bit operations and write-back
  // ----------------------------------------
  wire [7:0] bitMask = 8'h01 << bitSel;
  wire bitVal = |(fileRd & bitMask);
  wire [7:0] bitRes = bitOp[0] ? (fileRd | bitMask) : (fileRd & ~bitMask);
  wire bitWr = isBit & ~bitOp[1];
  wire skip = isBit & bitOp[1] & (bitOp[0] ? bitVal : ~bitVal);
  wire fileWe = (byteWr & destFile) | isMovwf | bitWr;
  wire [7:0] fileWd = isMovwf ? acc_r : (isBit ? bitRes : aluRes);
  wire accWe = (byteWr & ~destFile) | (isLit & litKnown);
  wire pclWr = fileWe & (physAddr == `MCF_FA_PCLOW);
  wire statusWr = fileWe & (physAddr == `MCF_FA_STATUS);

  // A flag-producing result wins over its own write to those bits
  wire [2:0] stBase = (statusWr & (affMask == 3'b000)) ? fileWd[2:0] : status_r[2:0];
  wire [2:0] stNext = (stBase & ~affMask) | ({aluZ, aluNib, aluC} & affMask);

  // ----------------------------------------
  // Next program counter
  // ----------------------------------------
  wire [9:0] stackTop;
  wire flowChange = isJump | doPop | pclWr | skip;
  wire accept = irValid_r & irqReq & ~intBusy_r & ~flowChange;
  reg [9:0] pcNext;
  reg doPush;
  reg flush;

  always @* begin
    pcNext = pc_r + 10'h001;
    doPush = 1'b0;
    flush = 1'b1;
    if (isJump) begin
      pcNext = ir_r[9:0];
      doPush = isCall;
    end else if (doPop) begin
      pcNext = stackTop;
    end else if (pclWr) begin
      pcNext = {pc_r[9:8], fileWd};
    end else if (accept) begin
      pcNext = `MCF_VEC_INT;
      doPush = 1'b1;
    end else if (!skip) begin
      flush = 1'b0;
    end
  end

  // Return address is the fetched word's address, which is discarded
  mcf_stack uStack (
    .clk(clk),
    .rst_b(rst_b),
    .push(execEdge & doPush),
    .pop(execEdge & doPop),
    .pushAddr(pc_r),
    .topAddr(stackTop)
  );

  // ----------------------------------------
  // Phase sequencer and execute
  // ----------------------------------------
  // Counter moves on entry to phase one so ROM has two clocks to answer
  always @(posedge clk) begin
    if (!rst_b) begin
      phase_r <= PH_ONE;
      pc_r <= `MCF_VEC_RESET;
      ir_r <= 14'h0000;
      irValid_r <= 1'b0;
      acc_r <= `MCF_ACC_RESET;
      status_r <= `MCF_STATUS_RESET;
      pointer_r <= 8'h00;
      intBusy_r <= 1'b0;
      intRetSeen_r <= 1'b0;
    end else if (runEn_r) begin
      phase_r <= (phase_r == PH_ONE) ? PH_TWO : PH_ONE;
      if (phase_r == PH_TWO) begin
        pc_r <= pcNext;
        ir_r <= romData;
        irValid_r <= ~flush;
        if (accWe) begin
          acc_r <= aluRes;
        end
        status_r <= {status_r[7:3], stNext};
        if (fileWe && physAddr == `MCF_FA_POINTER) begin
          pointer_r <= fileWd;
        end
        if (accept) begin
          intBusy_r <= 1'b1;
        end else if (intRetSeen_r && irValid_r) begin
          intBusy_r <= 1'b0;
          intRetSeen_r <= 1'b0;
        end
        if (isIntRet) begin
          intRetSeen_r <= 1'b1;
        end
      end
    end
  end

  // General RAM has no reset, as plain static memory
  always @(posedge clk) begin
    if (execEdge && fileWe && isRam) begin
      ram_r[ramIdx] <= fileWd;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      wpWrEn_r <= 1'b0;
      wpAddr_r <= 3'h0;
      wpData_r <= 8'h00;
    end else begin
      wpWrEn_r <= execEdge & isToWplane;
      if (execEdge && isToWplane) begin
        wpAddr_r <= ir_r[2:0];
        wpData_r <= acc_r;
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire wbReq = wbCyc & wbStb & ~wbAck_r;
  wire wbCommit = wbCyc & wbStb & wbAck_r & wbWe;

  always @(posedge clk) begin
    if (!rst_b) begin
      wbAck_r <= 1'b0;
      wbDatR_r <= 32'h00000000;
      runEn_r <= `MCF_CTRL_RESET;
    end else begin
      wbAck_r <= wbReq;
      if (wbReq) begin
        case (wbAdr)
          `MCF_ADR_CTRL: wbDatR_r <= {31'h00000000, runEn_r};
          `MCF_ADR_STATE: wbDatR_r <= {13'h0000, phase_r, intBusy_r, irValid_r, 6'h00, pc_r};
          `MCF_ADR_DATA: wbDatR_r <= {8'h00, pointer_r, status_r, acc_r};
          default: wbDatR_r <= 32'h00000000;
        endcase
      end
      if (wbCommit && wbAdr == `MCF_ADR_CTRL && wbSel[0]) begin
        runEn_r <= wbDatW[`MCF_CTRL_RUN_BIT];
      end
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatR = wbDatR_r;
  assign romAddr = pc_r;
  assign phaseTwo = phase_r;
  assign intBusy = intBusy_r;
endmodule

// File: mcf_core_properties.sv
`timescale 1ns/1ps
module mcf_core_properties (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Program fetch and core state
  input wire [9:0] romAddr,
  input wire [13:0] romData,
  input wire phaseTwo,
  input wire intBusy,
  input wire irqReq,
  // Write-only plane
  input wire wpWrEn_r,
  input wire [2:0] wpAddr_r,
  input wire [7:0] wpData_r,
  // Wishbone
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  input wire wbAck,
  input wire [31:0] wbDatR
);
  // Run bit mirrored so phase checks pause while frozen
  logic runEn_r;
  always @(posedge clk) begin
    if (!rst_b) begin
      runEn_r <= 1'h1;
    end else if (wbAck && wbCyc && wbStb && wbWe && wbAdr == 8'h00 && wbSel[0]) begin
      runEn_r <= wbDatW[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_released; !$past(rst_b); endsequence
  sequence s_firstFetch; ##2 romAddr == 10'h001; endsequence
  property p_phaseToggle; runEn_r |=> phaseTwo != $past(phaseTwo); endproperty
  a_phaseToggle: assert property (p_phaseToggle) else $error("phase did not alternate");
  property p_romHold; $fell(phaseTwo) |=> $stable(romAddr); endproperty
  a_romHold: assert property (p_romHold) else $error("fetch address moved in phase two");
  property p_romMove; $changed(romAddr) |-> $past(phaseTwo); endproperty
  a_romMove: assert property (p_romMove) else $error("fetch address moved off phase one");
  property p_resetVec; s_released |-> romAddr == 10'h000 && !phaseTwo && !intBusy && !wpWrEn_r; endproperty
  a_resetVec: assert property (p_resetVec) else $error("reset state wrong");
  property p_firstStep; s_released |-> s_firstFetch; endproperty
  a_firstStep: assert property (p_firstStep) else $error("first fetch step wrong");
  property p_wpPulse; $rose(wpWrEn_r) |-> !phaseTwo ##1 !wpWrEn_r; endproperty
  a_wpPulse: assert property (p_wpPulse) else $error("plane write strobe wrong");
  property p_intVec; $rose(intBusy) |-> romAddr == 10'h001 && $past(irqReq); endproperty
  a_intVec: assert property (p_intVec) else $error("interrupt entry wrong");
  property p_ackResp; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
  a_ackResp: assert property (p_ackResp) else $error("bus ack late");
  property p_ackOne; wbAck |=> !wbAck; endproperty
  a_ackOne: assert property (p_ackOne) else $error("bus ack too long");
endmodule
bind mcf_core mcf_core_properties u_props (.clk(clk), .rst_b(rst_b), .romAddr(romAddr), .romData(romData),
  .phaseTwo(phaseTwo), .intBusy(intBusy), .irqReq(irqReq), .wpWrEn_r(wpWrEn_r), .wpAddr_r(wpAddr_r),
  .wpData_r(wpData_r), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
  .wbDatW(wbDatW), .wbAck(wbAck), .wbDatR(wbDatR));

// File: mcf_core_regs.vh
`ifndef MCF_CORE_REGS_VH
`define MCF_CORE_REGS_VH

// ----------------------------------------
// Bus register map
// ----------------------------------------
`define MCF_ADR_CTRL 8'h00
`define MCF_ADR_STATE 8'h04
`define MCF_ADR_DATA 8'h08
`define MCF_CTRL_RUN_BIT 0
`define MCF_CTRL_RESET 1'b1

// ----------------------------------------
// Program counter and stack
// ----------------------------------------
`define MCF_VEC_RESET 10'h000
`define MCF_VEC_INT 10'h001
`define MCF_STACK_DEPTH 5

// ----------------------------------------
// File plane
// ----------------------------------------
`define MCF_FA_INDIRECT 6'h00
`define MCF_FA_PCLOW 6'h02
`define MCF_FA_STATUS 6'h03
`define MCF_FA_POINTER 6'h04
`define MCF_FA_RAM_BASE 6'h10
`define MCF_RAM_WORDS 48
`define MCF_STATUS_RESET 8'h00
`define MCF_ACC_RESET 8'h00

// ----------------------------------------
// Instruction encoding
// ----------------------------------------
`define MCF_GRP_BYTE 2'h0
`define MCF_GRP_BIT 2'h1
`define MCF_GRP_JUMP 2'h2
`define MCF_GRP_LIT 2'h3
`define MCF_OP_MOVWF 4'h0
`define MCF_OP_MISC 4'hE
`define MCF_OP_NONE 4'hF
`define MCF_MISC_RET 3'h1
`define MCF_MISC_INTRET 3'h2
`define MCF_LIT_MOVLW 4'h0
`define MCF_LIT_RETVAL 4'h1
`define MCF_LIT_ADDLW 4'h2
`define MCF_LIT_SUBLW 4'h3
`define MCF_LIT_ANDLW 4'h4
`define MCF_LIT_IORLW 4'h5
`define MCF_LIT_XORLW 4'h6

// ----------------------------------------
// Arithmetic unit operations
// ----------------------------------------
`define MCF_ALU_PASS 4'h0
`define MCF_ALU_CLR 4'h1
`define MCF_ALU_SUB 4'h2
`define MCF_ALU_DEC 4'h3
`define MCF_ALU_IOR 4'h4
`define MCF_ALU_AND 4'h5
`define MCF_ALU_XOR 4'h6
`define MCF_ALU_ADD 4'h7
`define MCF_ALU_MOVF 4'h8
`define MCF_ALU_COM 4'h9
`define MCF_ALU_INC 4'hA
`define MCF_ALU_RR 4'hB
`define MCF_ALU_RL 4'hC
`define MCF_ALU_SWAP 4'hD
`endif

// File: mcf_rom_model.sv
`timescale 1ns/1ps
module mcf_rom_model (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Program fetch
  input wire [9:0] romAddr,
  input wire phaseTwo,
  output wire [13:0] romData,
  // Write-only plane
  input wire wpWrEn_r,
  input wire [2:0] wpAddr_r,
  input wire [7:0] wpData_r
);
  logic [13:0] mem [0:1023];
  logic [7:0] plane [0:7];
  logic [9:0] fetchLog [$];
  int wrCount;
  assign romData = mem[romAddr];
  task automatic clear;
    foreach (mem[i]) mem[i] = 14'h0F00;
    foreach (plane[i]) plane[i] = 8'hEE;
    fetchLog.delete();
    wrCount = 0;
  endtask
  // Plane has no read path: only the write strobe is seen
  always @(posedge clk) begin
    if (rst_b && phaseTwo === 1'h1) fetchLog.push_back(romAddr);
    if (rst_b && wpWrEn_r === 1'h1) begin
      plane[wpAddr_r] <= wpData_r;
      wrCount++;
    end
  end
endmodule

// File: mcf_stack.v
`timescale 1ns/1ps
`include "mcf_core_regs.vh"
module mcf_stack (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Push and pop
  input wire push,
  input wire pop,
  input wire [9:0] pushAddr,
  // Top entry
  output wire [9:0] topAddr
);
  // Entry 0 is the top; a sixth push drops the oldest entry
  reg [10*`MCF_STACK_DEPTH-1:0] levels_r;
  wire [10*`MCF_STACK_DEPTH-1:0] shiftIn = {levels_r[10*`MCF_STACK_DEPTH-11:0], pushAddr};
  wire [10*`MCF_STACK_DEPTH-1:0] shiftOut = {10'h000, levels_r[10*`MCF_STACK_DEPTH-1:10]};

  assign topAddr = levels_r[9:0];

  always @(posedge clk) begin
    if (!rst_b) begin
      levels_r <= {(10*`MCF_STACK_DEPTH){1'b0}};
    end else if (push) begin
      levels_r <= shiftIn;
    end else if (pop) begin
      levels_r <= shiftOut;
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, rst_b = 1'h0, irqReq = 1'h0, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatW = 32'h0, rd, rd2;
  wire [9:0] romAddr;
  wire [13:0] romData;
  wire [2:0] wpAddr_r;
  wire [7:0] wpData_r;
  wire [31:0] wbDatR;
  wire wpWrEn_r, phaseTwo, intBusy, wbAck;
  int err_count = 0, comparisons = 0;
  always #5 clk = ~clk;
  mcf_core DUT (.clk(clk), .rst_b(rst_b), .romAddr(romAddr), .romData(romData), .wpWrEn_r(wpWrEn_r),
    .wpAddr_r(wpAddr_r), .wpData_r(wpData_r), .irqReq(irqReq), .phaseTwo(phaseTwo), .intBusy(intBusy),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbAck(wbAck), .wbDatR(wbDatR));
  mcf_rom_model rom (.clk(clk), .rst_b(rst_b), .romAddr(romAddr), .phaseTwo(phaseTwo), .romData(romData),
    .wpWrEn_r(wpWrEn_r), .wpAddr_r(wpAddr_r), .wpData_r(wpData_r));
  // ----------------------------------------
  // Encoders and bus helpers
  // ----------------------------------------
  function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
    return {2'h3, op, k};
  endfunction
  function automatic logic [13:0] byt(input logic [3:0] op, input logic d, input logic [5:0] f);
    return {2'h0, op, d, 1'h0, f};
  endfunction
  function automatic logic [13:0] jmp(input logic g, input logic [9:0] t);
    return {2'h2, g, 1'h0, t};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Reset held while the program image is loaded
  task automatic restart;
    @(posedge clk);
    rst_b <= 1'h0;
    // Clear only once reset holds, so no late fetch lands in the log
    @(posedge clk);
    rom.clear();
  endtask
  task automatic go(input int n);
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    repeat (n) @(posedge clk);
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dw, output logic [31:0] dr);
    int n;
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dw;
    n = 0;
    // Only the watchdog ends a wait for an answer that never comes
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'h1);
    dr = wbDatR;
    chk("wbWait", 2, n);
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_flow;
    logic [9:0] ex [7] = '{10'h000, 10'h001, 10'h205, 10'h206, 10'h207, 10'h208, 10'h25A};
    restart();
    rom.mem[0] = jmp(1'h1, 10'h205);
    rom.mem[1] = byt(4'h0, 1'h0, 6'h05);
    rom.mem[10'h205] = lit(4'h0, 8'h5A);
    rom.mem[10'h206] = byt(4'h0, 1'h0, 6'h03);
    rom.mem[10'h207] = byt(4'h0, 1'h1, 6'h02);
    rom.mem[10'h25A] = jmp(1'h1, 10'h25A);
    go(40);
    foreach (ex[i]) chk("fetch", ex[i], rom.fetchLog[i]);
    chk("plane3", 8'h5A, rom.plane[3]);
    chk("writes", 1, rom.wrCount);
  endtask
  task automatic t_alu;
    logic [13:0] pg [$];
    logic [7:0] ex [8] = '{8'h07, 8'hFE, 8'h00, 8'h03, 8'hA6, 8'h80, 8'h03, 8'hC0};
    restart();
    pg = '{lit(4'h0, 8'h0F), lit(4'h2, 8'hF1), byt(4'h8, 1'h0, 6'h03), byt(4'h0, 1'h0, 6'h00),
      lit(4'h0, 8'h05), lit(4'h3, 8'h03), byt(4'h0, 1'h0, 6'h01), byt(4'h8, 1'h0, 6'h03),
      byt(4'h0, 1'h0, 6'h02), lit(4'h0, 8'h04), lit(4'h3, 8'h05), byt(4'h8, 1'h0, 6'h03),
      byt(4'h0, 1'h0, 6'h03), lit(4'h0, 8'h25), byt(4'h0, 1'h1, 6'h04), lit(4'h0, 8'hA6),
      byt(4'h0, 1'h1, 6'h00), byt(4'h8, 1'h0, 6'h25), byt(4'h0, 1'h0, 6'h04), byt(4'h1, 1'h1, 6'h11),
      {2'h1, 2'h1, 3'h7, 2'h0, 5'h11}, byt(4'h8, 1'h0, 6'h11), byt(4'h0, 1'h0, 6'h05),
      lit(4'h0, 8'hFF), byt(4'h7, 1'h1, 6'h03), byt(4'h8, 1'h0, 6'h03), byt(4'h0, 1'h0, 6'h06),
      lit(4'h0, 8'h81), byt(4'h0, 1'h1, 6'h12), byt(4'hB, 1'h0, 6'h12), byt(4'h0, 1'h0, 6'h07),
      jmp(1'h1, 10'h01F)};
    foreach (pg[i]) rom.mem[i] = pg[i];
    go(100);
    foreach (ex[i]) chk("result", ex[i], rom.plane[i]);
    wb(1'h0, 8'h08, 32'h0, rd);
    chk("acc", 32'h002503C0, rd);
  endtask
  task automatic t_irq;
    int k, n;
    restart();
    rom.mem[0] = jmp(1'h1, 10'h010);
    rom.mem[1] = lit(4'h0, 8'h77);
    rom.mem[2] = byt(4'hE, 1'h0, 6'h02);
    rom.mem[10'h010] = jmp(1'h0, 10'h200);
    rom.mem[10'h011] = byt(4'h0, 1'h0, 6'h00);
    for (int i = 0; i < 4; i++) begin
      rom.mem[10'h200 + 16 * i] = jmp(1'h0, 10'h210 + 16 * i);
      rom.mem[10'h201 + 16 * i] = byt(4'hE, 1'h0, 6'h01);
    end
    rom.mem[10'h240] = lit(4'h1, 8'h33);
    go(70);
    chk("nested", 8'h33, rom.plane[0]);
    irqReq <= 1'h1;
    n = 0;
    while (intBusy !== 1'h1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("vector", 10'h001, romAddr);
    irqReq <= 1'h0;
    repeat (30) @(posedge clk);
    chk("busy", 0, intBusy);
    wb(1'h0, 8'h08, 32'h0, rd);
    chk("isrAcc", 8'h77, rd[7:0]);
    foreach (rom.fetchLog[i]) if (rom.fetchLog[i] == 10'h001) k = i;
    chk("resume", rom.fetchLog[k - 1], rom.fetchLog[k + 3]);
  endtask
  task automatic t_misc;
    logic [13:0] pg [$];
    logic [7:0] ex [6] = '{8'h5C, 8'h3A, 8'hA3, 8'h48, 8'h48, 8'h24};
    restart();
    pg = '{lit(4'h0, 8'h3C), lit(4'h4, 8'h0F), lit(4'h5, 8'h50), lit(4'h6, 8'hFF),
      byt(4'h0, 1'h1, 6'h10), byt(4'h9, 1'h0, 6'h10), byt(4'h0, 1'h0, 6'h00),
      byt(4'hD, 1'h0, 6'h10), byt(4'h0, 1'h0, 6'h01), byt(4'hA, 1'h1, 6'h10),
      byt(4'h3, 1'h0, 6'h10), byt(4'h0, 1'h0, 6'h02), byt(4'hC, 1'h0, 6'h10),
      byt(4'h0, 1'h0, 6'h03), {2'h1, 2'h3, 3'h0, 2'h0, 5'h03}, lit(4'h0, 8'h11),
      {2'h1, 2'h2, 3'h2, 2'h0, 5'h03}, lit(4'h0, 8'h22), byt(4'h0, 1'h0, 6'h04),
      {2'h1, 2'h0, 3'h7, 2'h0, 5'h10}, byt(4'h8, 1'h0, 6'h10), byt(4'h0, 1'h0, 6'h05),
      jmp(1'h1, 10'h016)};
    foreach (pg[i]) rom.mem[i] = pg[i];
    go(80);
    foreach (ex[i]) chk("misc", ex[i], rom.plane[i]);
  endtask
  task automatic t_bus;
    wb(1'h0, 8'h0C, 32'h0, rd);
    chk("unmapped", 0, rd);
    wbSel <= 4'hE;
    wb(1'h1, 8'h00, 32'h0, rd);
    wbSel <= 4'hF;
    wb(1'h0, 8'h00, 32'h0, rd);
    chk("ctrlMasked", 1, rd);
    wb(1'h1, 8'h00, 32'h0, rd);
    wb(1'h0, 8'h04, 32'h0, rd);
    repeat (6) @(posedge clk);
    wb(1'h0, 8'h04, 32'h0, rd2);
    chk("frozen", rd, rd2);
    wb(1'h1, 8'h00, 32'h1, rd);
  endtask
  initial begin
    t_flow();
    t_alu();
    t_misc();
    t_irq();
    t_bus();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
